// ---- hw/xct_board_test.sv ----
`timescale 1ns/1ps
// Function
// - reset release with frame and bit0 both low enters board test mode.
// - reset release with frame or bit0 high leaves board test mode.
// - in test mode normal pin functions detach; all pins are inputs but output.
// - host reset pin never feeds the parity chain.
// - chain result drives the tach / general pin 31 pad in test mode.
// - flipping any single chain input flips the chain output.
// - frame and bit0 become ordinary chain inputs once in test mode.
// - supply power-on reset clears test mode.
// - after exit, chain inputs no longer affect the output pin.
// - all chain inputs low gives low output.
// - all chain inputs high gives low output; even input count.
module xct_board_test (
	// clock, clock enable and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	// host reset and selection pins
	input wire logic host_reset_low,
	input wire logic bus_cycle_frame_low,
	input wire logic bus_addr_data_bit0,
	// remaining chain pins
	input wire logic [xct_pkg::XCT_OTHER_W-1:0] chain_pins,
	// normal function of the tach / general_pin_31 pad
	input wire logic general_pin_31_o,
	input wire logic general_pin_31_oe,
	// pad drive and detach status
	output logic chain_result_pin_o,
	output logic chain_result_pin_oe,
	output logic test_mode
);
	import xct_pkg::*;

	// ----------------------------------------
	// parity chain
	// ----------------------------------------
	function automatic logic xct_parity(input logic [XCT_CHAIN_W-1:0] v);
		xct_parity = ^v;
	endfunction : xct_parity

	logic mode_q;
	logic mode_d;
	logic host_reset_q;
	logic pin_o_q;
	logic pin_o_d;
	logic pin_oe_q;
	logic pin_oe_d;

	// the host reset is deliberately absent from this vector
	wire [XCT_CHAIN_W-1:0] chain_vec = {bus_cycle_frame_low, bus_addr_data_bit0, chain_pins};
	wire chain_xor = xct_parity(chain_vec);
	wire reset_rise = host_reset_low & ~host_reset_q;
	wire select_test = ~bus_cycle_frame_low & ~bus_addr_data_bit0;

	// ----------------------------------------
	// mode flag
	// ----------------------------------------
	assign mode_d = reset_rise ? select_test : mode_q;
	// one register stage on the pad keeps outputs glitch free, at one cycle of latency
	assign pin_o_d = mode_q ? chain_xor : general_pin_31_o;
	assign pin_oe_d = mode_q ? 1'b1 : general_pin_31_oe;

	// mode flag: moves only at a host reset release or a power-on reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= XCT_MODE_RST;
		end
		else if (en)
		begin
			mode_q <= mode_d;
		end
	end

	// the sampler resets to the released level: a power-on reset that ends with the host
	// reset already high is not a rise, so grounded selection pins cannot enter the mode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_reset_q <= XCT_RESET_PIN_RST;
		end
		else if (en)
		begin
			host_reset_q <= host_reset_low;
		end
	end

	// ----------------------------------------
	// pad drive
	// ----------------------------------------
	// value side of the pad; the chain reaches it only while mode_q is set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_o_q <= XCT_PIN_O_RST;
		end
		else if (en)
		begin
			pin_o_q <= pin_o_d;
		end
	end

	// enable side of the pad; released after power-on so the general pin owns it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_oe_q <= XCT_PIN_OE_RST;
		end
		else if (en)
		begin
			pin_oe_q <= pin_oe_d;
		end
	end

	assign chain_result_pin_o = pin_o_q;
	assign chain_result_pin_oe = pin_oe_q;
	// tells the core to release every other pad
	assign test_mode = mode_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// sequences
	// ----------------------------------------

	sequence s_release;
		en && reset_rise;
	endsequence

	// an enabled cycle inside test mode
	sequence s_armed;
		en && mode_q;
	endsequence

	// an enabled cycle in normal operation
	sequence s_normal;
		en && !mode_q;
	endsequence

	// a cycle with the clock enable low
	sequence s_frozen;
		!en;
	endsequence

	chk_mode_entry_sel: assert property (s_release and select_test |=> mode_q)
		else $error("test mode not entered");
	chk_mode_exit_sel: assert property (s_release and !select_test |=> !mode_q)
		else $error("test mode not left");
	chk_mode_hold_only: assert property (!(en && reset_rise) |=> $stable(mode_q))
		else $error("mode changed without reset release");
	chk_pad_drive_on: assert property (en && mode_q |=> chain_result_pin_oe)
		else $error("pad not driven in test mode");
	chk_pad_parity_out: assert property (en && mode_q |=> chain_result_pin_o == $past(chain_xor))
		else $error("pad does not show chain parity");
	chk_toggle_follows: assert property (en && mode_q ##1 en && mode_q && $changed(chain_xor)
		|=> $changed(chain_result_pin_o))
		else $error("output did not toggle with input");
	chk_reset_not_chain: assert property (en && mode_q ##1 en && mode_q && $stable(chain_vec)
		|=> $stable(chain_result_pin_o))
		else $error("output moved with chain inputs stable");
	chk_exit_ignores: assert property (en && !mode_q |=> chain_result_pin_o == $past(general_pin_31_o))
		else $error("chain still reaches pad after exit");
	chk_all_low_zero: assert property (en && mode_q && chain_vec == XCT_ALL_LOW |=> !chain_result_pin_o)
		else $error("all low inputs gave high output");
	chk_all_high_zero: assert property (en && mode_q && chain_vec == XCT_ALL_HIGH |=> !chain_result_pin_o)
		else $error("all high inputs gave high output");
	chk_sel_in_chain: assert property (en && mode_q ##1 en && mode_q && $changed(bus_addr_data_bit0)
		&& $stable(bus_cycle_frame_low) && $stable(chain_pins) |=> $changed(chain_result_pin_o))
		else $error("bit0 not part of chain");
	// frame and bit0 are plain chain members once the flag is set
	chk_frame_in_chain: assert property (s_armed ##1 en && mode_q && $changed(bus_cycle_frame_low)
		&& $stable(bus_addr_data_bit0) && $stable(chain_pins) |=> $changed(chain_result_pin_o))
		else $error("frame not part of chain");
	chk_sel_ignored: assert property (s_armed ##1 en && mode_q && !reset_rise && $changed(select_test)
		|=> mode_q)
		else $error("selection pins acted outside a reset release");

	// ----------------------------------------
	// host reset isolation
	// ----------------------------------------
	// the host reset may move while the chain is watched; only its rise acts, and only on the flag
	chk_host_reset_free: assert property (s_armed ##1 en && mode_q && $changed(host_reset_low)
		&& $stable(chain_vec) |=> $stable(chain_result_pin_o))
		else $error("host reset reached the chain output");
	chk_entry_drives: assert property ((s_release and select_test) ##1 en |=> chain_result_pin_oe)
		else $error("pad not driven after entry");
	// any change of the flag outside power-on reset needs an enabled rise one cycle before
	chk_mode_cause: assert property ($changed(mode_q) |-> $past(en) && $past(reset_rise))
		else $error("mode flag moved without a host reset rise");

	// ----------------------------------------
	// clock enable
	// ----------------------------------------
	// a frozen cycle must leave the flag and both pad flops untouched
	chk_freeze_mode: assert property (s_frozen |=> $stable(mode_q))
		else $error("mode flag moved with enable low");
	chk_freeze_pad: assert property (s_frozen |=> $stable(chain_result_pin_o))
		else $error("pad value moved with enable low");
	chk_freeze_oe: assert property (s_frozen |=> $stable(chain_result_pin_oe))
		else $error("pad enable moved with enable low");

	// ----------------------------------------
	// normal operation
	// ----------------------------------------
	// outside test mode the pad belongs to the general pin again, enable included
	chk_exit_oe_follows: assert property (s_normal |=> chain_result_pin_oe == $past(general_pin_31_oe))
		else $error("pad enable not handed back after exit");
	chk_exit_no_toggle: assert property (s_normal ##1 (en && !mode_q && $changed(chain_xor)
		&& $stable(general_pin_31_o)) |=> $stable(chain_result_pin_o))
		else $error("chain still toggles the pad after exit");

endmodule : xct_board_test

// ---- common/xct_pkg.sv ----
package xct_pkg;

	// chain inputs besides the two selection pins
	localparam int XCT_OTHER_W = 86;
	// full chain width, kept even so all-high gives a low result
	localparam int XCT_CHAIN_W = 88;
	localparam int XCT_FRAME_POS = 87;
	localparam int XCT_AD0_POS = 86;
	localparam logic XCT_MODE_RST = 1'b0;
	// released level, so the end of a power-on reset alone never looks like a rise
	localparam logic XCT_RESET_PIN_RST = 1'b1;
	localparam logic XCT_PIN_O_RST = 1'b0;
	localparam logic XCT_PIN_OE_RST = 1'b0;
	localparam logic [XCT_CHAIN_W-1:0] XCT_ALL_LOW = '0;
	localparam logic [XCT_CHAIN_W-1:0] XCT_ALL_HIGH = '1;

endpackage : xct_pkg

// ---- verif/xct_tester.sv ----
`timescale 1ns/1ps
// board tester: launches pin levels just after the edge
module xct_tester (
	// clock
	input wire logic clk,
	// requested and driven levels, top bit is host reset
	input wire logic [xct_pkg::XCT_CHAIN_W:0] want,
	output logic [xct_pkg::XCT_CHAIN_W:0] pins = '0
);
	always @(posedge clk)
		pins <= want;
endmodule : xct_tester

// ---- verif/tb_xct_board_test.sv ----
`timescale 1ns/1ps
module tb_xct_board_test;
	import xct_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [XCT_CHAIN_W:0] want = '0;
	logic [XCT_CHAIN_W:0] pins;
	logic pad_o, pad_oe, mode;
	logic en = 1'b1;
	int n_errors = 0;
	int checks_done = 0;
	always #5 clk = ~clk;
	xct_tester xct_tester_inst (.clk(clk), .want(want), .pins(pins));
	// normal pad drive tied high and undriven, so exit shows as oe low
	xct_board_test xct_board_test_inst (.clk(clk), .rst_n(rst_n), .en(en), .host_reset_low(pins[XCT_CHAIN_W]),
		.bus_cycle_frame_low(pins[XCT_FRAME_POS]), .bus_addr_data_bit0(pins[XCT_AD0_POS]),
		.chain_pins(pins[XCT_OTHER_W-1:0]), .general_pin_31_o(1'b1), .general_pin_31_oe(1'b0),
		.chain_result_pin_o(pad_o), .chain_result_pin_oe(pad_oe), .test_mode(mode));
	task automatic chk(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// four edges covers tester stage, mode flag and registered pad
	task automatic step(input int i, input logic v);
		want[i] <= v;
		repeat (4) @(posedge clk);
	endtask : step
	task automatic walk_chain;
		logic par;
		par = 1'b0;
		step(XCT_CHAIN_W, 1'b1);
		chk(mode, 1'b1);
		chk(pad_oe, 1'b1);
		chk(pad_o, 1'b0);
		for (int i = XCT_CHAIN_W - 1; i >= 0; i--)
		begin
			step(i, 1'b1);
			par = ~par;
			chk(pad_o, par);
		end
		chk(pad_o, 1'b0);
		step(XCT_CHAIN_W, 1'b0);
		chk(pad_o, 1'b0);
		$display("walk_chain done");
	endtask : walk_chain
	// with the enable low a chain change must not reach the pad
	task automatic freeze_hold;
		en <= 1'b0;
		step(0, 1'b0);
		chk(pad_o, 1'b0);
		chk(mode, 1'b1);
		en <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pad_o, 1'b1);
		step(0, 1'b1);
		$display("freeze_hold done");
	endtask : freeze_hold
	task automatic leave_mode;
		step(XCT_CHAIN_W, 1'b1);
		chk(mode, 1'b0);
		step(0, 1'b0);
		chk(pad_o, 1'b1);
		chk(pad_oe, 1'b0);
		$display("leave_mode done");
	endtask : leave_mode
	// selection pins stay low through the power-on reset, so only that reset can clear the mode
	task automatic power_clear;
		want <= '0;
		repeat (4) @(posedge clk);
		step(XCT_CHAIN_W, 1'b1);
		chk(mode, 1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(mode, 1'b0);
		$display("power_clear done");
	endtask : power_clear
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		walk_chain();
		freeze_hold();
		leave_mode();
		power_clear();
		close_out();
	end
endmodule : tb_xct_board_test
